/* File: pkg/pfl_pkg.sv */
// Purpose: constants and types shared by the fast link control block
// Assumes: 20 MHz system clock
// Notes:   register numbers are management register addresses
package pfl_pkg;

    // ********************************
    // register addresses and field positions
    // ********************************
    localparam logic [4:0]  REG_STATUS = 5'h1c;
    localparam logic [4:0]  REG_CTRL   = 5'h1d;
    localparam int          ST_FAST    = 1;
    localparam int          ST_SLOW    = 0;
    localparam int          F_SRST     = 15;
    localparam int          F_TSTA     = 14;
    localparam int          F_TSTB     = 13;
    localparam int          F_TXON     = 12;
    localparam int          F_BLINK    = 11;
    localparam int          F_CRS      = 10;
    localparam int          F_LNKERR   = 9;
    localparam int          F_PKTERR   = 8;
    localparam int          F_STR      = 7;
    localparam int          F_CODEC    = 6;
    localparam int          F_ALIGN    = 5;
    localparam int          F_SCR      = 4;
    localparam int          F_CARIN    = 3;
    localparam int          F_JAM      = 2;
    localparam int          F_FEF      = 1;
    localparam int          F_FIBER    = 0;
    localparam logic [15:0] CTRL_RESET = 16'h1000;

    // ********************************
    // receive error codes and synchroniser lanes
    // ********************************
    localparam logic [3:0]  LINK_ERR_CODE = 4'h2;
    localparam logic [3:0]  PACKET_ERROR_REPORT_ENABLE_CODE  = 4'h3;
    localparam int          S_BLINK  = 0;
    localparam int          S_CRS    = 1;
    localparam int          S_CODEC  = 2;
    localparam int          S_SCR    = 3;
    localparam int          S_CARIN  = 4;
    localparam int          S_FIBER  = 5;
    localparam int          S_MDC    = 6;
    localparam int          S_MDIO   = 7;
    localparam int          SYNC_W   = 8;

    // ********************************
    // timing
    // ********************************
    localparam int          CLK_NS          = 50;
    localparam int          STRETCH_MS      = 42;
    localparam int          STRETCH_CYC_DEF = (STRETCH_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int          STR_W           = 20;

    // ********************************
    // management frame
    // ********************************
    localparam logic [1:0]  OP_READ   = 2'b10;
    localparam logic [1:0]  OP_WRITE  = 2'b01;
    localparam logic [4:0]  HDR_LAST  = 5'h0b;
    localparam logic [4:0]  DATA_LAST = 5'h0f;

    typedef enum logic [2:0] {MD_IDLE, MD_START, MD_HDR, MD_TA, MD_DATA} pfl_md_state_t;

endpackage

/* File: pkg/pfl_mgmt_if.sv */
// Purpose: register access strobes between frame engine and register bank
// Assumes: single clock domain
// Notes:   rdata is combinational from the bank
`timescale 1ns/10ps
`default_nettype none
interface pfl_mgmt_if;
    logic        wr;
    logic [4:0]  regad;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport engine (output wr, regad, wdata, input rdata);
    modport regs   (input wr, regad, wdata, output rdata);
endinterface
`default_nettype wire

/* File: hdl/pfl_sync.sv */
// Purpose: two stage synchroniser for pin inputs
// Assumes: inputs asynchronous to mclk_i
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module pfl_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk_i,   // system clock
    input  wire logic         arst_n_i, // async reset, low
    input  wire logic [W-1:0] d_i,      // raw pins
    output logic      [W-1:0] q_o       // synchronised
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pfl_sync_t;

    pfl_sync_t r;
    pfl_sync_t next_r;

    // shift through both stages
    always_comb
    begin
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            r <= '0;
        else
            r <= next_r;
    end

    assign q_o = r.s2;
endmodule
`default_nettype wire

/* File: hdl/pfl_mdio.sv */
// Purpose: serial management frame engine, slave side
// Assumes: mdc and mdio already synchronised to mclk_i
// Notes:   preamble may be suppressed; mdc high and low >= 3 mclk
`timescale 1ns/10ps
`default_nettype none
module pfl_mdio
    import pfl_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input  wire logic  mclk_i,    // system clock
    input  wire logic  arst_n_i,  // async reset, low
    input  wire logic  mdc_s_i,   // synced mgmt clock
    input  wire logic  mdio_s_i,  // synced mgmt data
    output logic       mdio_o,    // data driven out
    output logic       mdio_oe_o, // drive enable
    pfl_mgmt_if.engine mgmt       // register strobes
);
    typedef struct packed {
        pfl_md_state_t st;
        logic          mdc_d;
        logic [4:0]    cnt;
        logic [15:0]   sh;
        logic          rd;
        logic          hit;
        logic          wr;
        logic [4:0]    regad;
        logic          mdo;
        logic          oe;
    } pfl_md_t;

    pfl_md_t r;
    pfl_md_t next_r;

    // ********************************
    // frame sequencing, one step per mdc rising edge
    // ********************************
    always_comb
    begin
        next_r       = r;
        next_r.wr    = 1'b0;
        next_r.mdc_d = mdc_s_i;
        if (mdc_s_i && !r.mdc_d)
        begin
            unique case (r.st)
                MD_IDLE:
                    if (!mdio_s_i)
                        next_r.st = MD_START;
                MD_START:
                begin
                    next_r.st  = mdio_s_i ? MD_HDR : MD_IDLE;
                    next_r.cnt = '0;
                end
                MD_HDR:
                begin
                    next_r.sh  = {r.sh[14:0], mdio_s_i};
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == HDR_LAST)
                    begin
                        // op sits in sh[10:9], address in sh[8:4]
                        next_r.st    = MD_TA;
                        next_r.cnt   = '0;
                        next_r.rd    = (r.sh[10:9] == OP_READ);
                        next_r.hit   = (r.sh[8:4] == PHY_ADDR) &&
                                       (r.sh[10:9] == OP_READ || r.sh[10:9] == OP_WRITE);
                        next_r.regad = {r.sh[3:0], mdio_s_i};
                    end
                end
                MD_TA:
                begin
                    next_r.cnt = 5'h01;
                    if (r.cnt == '0)
                    begin
                        // drive the second turnaround bit low
                        next_r.oe  = r.rd && r.hit;
                        next_r.mdo = 1'b0;
                    end
                    else
                    begin
                        next_r.st  = MD_DATA;
                        next_r.cnt = '0;
                        next_r.sh  = {mgmt.rdata[14:0], 1'b0};
                        next_r.mdo = mgmt.rdata[15];
                    end
                end
                MD_DATA:
                begin
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.rd)
                    begin
                        next_r.mdo = r.sh[15];
                        next_r.sh  = {r.sh[14:0], 1'b0};
                    end
                    else
                        next_r.sh = {r.sh[14:0], mdio_s_i};
                    if (r.cnt == DATA_LAST)
                    begin
                        next_r.st = MD_IDLE;
                        next_r.oe = 1'b0;
                        next_r.wr = r.hit && !r.rd;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            r <= '{st: MD_IDLE, default: '0};
        else
            r <= next_r;
    end

    assign mdio_o      = r.mdo;
    assign mdio_oe_o   = r.oe;
    assign mgmt.wr     = r.wr;
    assign mgmt.regad  = r.regad;
    assign mgmt.wdata  = r.sh;
endmodule
`default_nettype wire

/* File: hdl/pfl_ctrl.sv */
// Purpose: fast link status and control registers with their port effects
// Assumes: link, activity and receive inputs come from logic on mclk_i
// Notes:   pins pass the synchroniser; all outputs registered
//
// What this block does
// RULE_01 - status bit 1 reads 1 while the 100 Mbit/s transceiver is up
// RULE_02 - status bit 0 reads 1 while the 10 Mbit/s transceiver is up
// RULE_03 - writing 1 to reset bit restores defaults, pulses reset, self clears
// RULE_04 - transmitter-off forces positive pair low, negative high; bit resets to 1
// RULE_05 - indicator blink enabled by register bit or blink input; default 0
// RULE_06 - carrier sense on receive only when select bit or pin set
// RULE_07 - link error enable places link error code on nibble with receive error
// RULE_08 - packet error enable places scrambler-unlocked code with receive error
// RULE_09 - stretch enable extends collision and activity outputs about 42 ms
// RULE_10 - codec bypass bit or pin disables 4B/5B encode and decode
// RULE_11 - aligner bypass bit disables code-group alignment
// RULE_12 - scrambler bypass bit or pin disables scrambling both ways
// RULE_13 - carrier integrity bit or pin enables integrity monitor
// RULE_14 - jam enable ORs integrity jam into collision carrier output
// RULE_15 - far-end fault enable turns on fault detection and sending; default 0
// RULE_16 - software sets far-end fault only without autonegotiation support; here the far-end fault bit is always writable, no autonegotiation check
// RULE_17 - fiber mode when fiber bit or fiber input is 1
// RULE_18 - control reads return last written fields; reset bit reads 0
`timescale 1ns/10ps
`default_nettype none
module pfl_ctrl
    import pfl_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR    = 5'h00,
    parameter int         STRETCH_CYC = STRETCH_CYC_DEF
) (
    input  wire logic       mclk_i,                         // system clock
    input  wire logic       arst_n_i,                       // async reset, low
    input  wire logic       mdc_i,                          // mgmt clock pin
    input  wire logic       mdio_i,                         // mgmt data in
    output logic            mdio_o,                         // mgmt data out
    output logic            mdio_oe_o,                      // mgmt data enable
    input  wire logic       fast_link_up_i,                 // 100M up
    input  wire logic       slow_link_up_i,                 // 10M up
    input  wire logic       tx_pos_i,                       // encoder pos
    input  wire logic       tx_neg_i,                       // encoder neg
    output logic            pair_out_pos_o,                 // pair positive
    output logic            pair_out_neg_o,                 // pair negative
    input  wire logic       indicator_blink_input_i,        // blink pin
    output logic            indicator_blink_o,              // blink enable
    input  wire logic       carrier_sense_receive_only_i,   // crs select pin
    input  wire logic       rx_active_i,                    // receiving
    input  wire logic       tx_active_i,                    // transmitting
    output logic            carrier_sense_out_o,            // carrier sense
    input  wire logic       rx_err_i,                       // receive error
    input  wire logic [3:0] rx_nibble_i,                    // receive data
    input  wire logic       link_fault_i,                   // link error seen
    input  wire logic       scr_unlocked_i,                 // scrambler unlocked
    output logic            receive_error_out_o,            // receive error out
    output logic [3:0]      receive_nibble_o,               // receive data out
    input  wire logic       col_i,                          // collision
    output logic            collision_indicator_o,          // stretched collision
    output logic            transmit_activity_indicator_o,  // stretched tx
    output logic            receive_activity_indicator_o,   // stretched rx
    input  wire logic       codec_bypass_pin_i,             // codec bypass pin
    output logic            codec_bypass_o,                 // codec bypass
    output logic            aligner_bypass_o,               // aligner bypass
    input  wire logic       scrambler_bypass_pin_i,         // scr bypass pin
    output logic            scrambler_bypass_o,             // scr bypass
    input  wire logic       carrier_integrity_enable_i,     // integrity pin
    output logic            carrier_integrity_enable_o,     // integrity on
    input  wire logic       jam_i,                          // integrity jam
    output logic            collision_carrier_out_o,        // collision carrier
    output logic            far_end_fault_enable_o,         // far-end fault on
    input  wire logic       fiber_mode_input_i,             // fiber pin
    output logic            fiber_mode_o,                   // fiber mode
    output logic            soft_reset_o                    // mgmt reset pulse
);
    localparam int CW = STR_W;

    typedef struct packed {
        logic [14:0]        ctl;
        logic               srst;
        logic               pos;
        logic               neg;
        logic               blink;
        logic               crs;
        logic               rxer;
        logic [3:0]         nib;
        logic [2:0]         act;
        logic [2:0][CW-1:0] cnt;
        logic               codec;
        logic               align;
        logic               scr;
        logic               carin;
        logic               colcrs;
        logic               fef;
        logic               fiber;
    } pfl_top_t;

    pfl_top_t       r;
    pfl_top_t       next_r;
    logic [SYNC_W-1:0] sy;
    logic [15:0]    status_word;

    pfl_mgmt_if mgmt ();

    // ********************************
    // pins and management frame engine
    // ********************************
    pfl_sync #(
        .W (SYNC_W)
    ) u_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({mdio_i, mdc_i, fiber_mode_input_i, carrier_integrity_enable_i,
                    scrambler_bypass_pin_i, codec_bypass_pin_i,
                    carrier_sense_receive_only_i, indicator_blink_input_i}),
        .q_o      (sy)
    );

    pfl_mdio #(
        .PHY_ADDR (PHY_ADDR)
    ) u_mdio (
        .mclk_i    (mclk_i),
        .arst_n_i  (arst_n_i),
        .mdc_s_i   (sy[S_MDC]),
        .mdio_s_i  (sy[S_MDIO]),
        .mdio_o    (mdio_o),
        .mdio_oe_o (mdio_oe_o),
        .mgmt      (mgmt.engine)
    );

    // ********************************
    // read path
    // ********************************
    // link levels are live, nothing latched here
    always_comb
    begin
        status_word          = '0;
        status_word[ST_FAST] = fast_link_up_i;  // see RULE_01
        status_word[ST_SLOW] = slow_link_up_i;  // see RULE_02
    end

    // unmapped addresses read zero; reset bit never stored
    assign mgmt.rdata = (mgmt.regad == REG_STATUS) ? status_word :
                        (mgmt.regad == REG_CTRL)   ? {1'b0, r.ctl} : 16'h0000;  // see RULE_18

    // ********************************
    // register update and port effects
    // ********************************
    always_comb
    begin
        logic [2:0] act_in;
        act_in    = {rx_active_i, tx_active_i, col_i};
        next_r    = r;
        next_r.srst = 1'b0;
        if (mgmt.wr && mgmt.regad == REG_CTRL)
        begin
            if (mgmt.wdata[F_SRST])
            begin
                next_r.ctl  = CTRL_RESET[14:0];  // see RULE_03
                next_r.srst = 1'b1;              // see RULE_03
            end
            else
                next_r.ctl = mgmt.wdata[14:0];   // see RULE_18
        end
        // idle line state when transmitter is off
        next_r.pos   = r.ctl[F_TXON] & tx_pos_i;              // see RULE_04
        next_r.neg   = ~r.ctl[F_TXON] | tx_neg_i;             // see RULE_04
        next_r.blink = r.ctl[F_BLINK] | sy[S_BLINK];          // see RULE_05
        next_r.crs   = rx_active_i |
                       (tx_active_i & ~(r.ctl[F_CRS] | sy[S_CRS]));  // see RULE_06
        // link error wins when both codes apply
        next_r.rxer = rx_err_i;
        if (rx_err_i && r.ctl[F_LNKERR] && link_fault_i)
            next_r.nib = LINK_ERR_CODE;                       // see RULE_07
        else if (rx_err_i && r.ctl[F_PKTERR] && scr_unlocked_i)
            next_r.nib = PACKET_ERROR_REPORT_ENABLE_CODE;                        // see RULE_08
        else
            next_r.nib = rx_nibble_i;
        // counters run always, so enabling mid-idle takes effect at once while a count is still nonzero
        for (int i = 0; i < 3; i++)
        begin
            next_r.cnt[i] = act_in[i] ? CW'(STRETCH_CYC) :
                            (r.cnt[i] != '0) ? r.cnt[i] - 1'b1 : '0;
            next_r.act[i] = act_in[i] | (r.ctl[F_STR] & (r.cnt[i] != '0));  // see RULE_09
        end
        next_r.codec  = r.ctl[F_CODEC] | sy[S_CODEC];         // see RULE_10
        next_r.align  = r.ctl[F_ALIGN];                       // see RULE_11
        next_r.scr    = r.ctl[F_SCR] | sy[S_SCR];             // see RULE_12
        next_r.carin  = r.ctl[F_CARIN] | sy[S_CARIN];         // see RULE_13
        next_r.colcrs = col_i | (jam_i & r.ctl[F_JAM]);       // see RULE_14
        next_r.fef    = r.ctl[F_FEF];                         // see RULE_15
        next_r.fiber  = r.ctl[F_FIBER] | sy[S_FIBER];         // see RULE_17
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            r <= '{ctl: CTRL_RESET[14:0], neg: 1'b1, default: '0};
        else
            r <= next_r;
    end

    // ********************************
    // outputs
    // ********************************
    assign pair_out_pos_o                = r.pos;
    assign pair_out_neg_o                = r.neg;
    assign indicator_blink_o             = r.blink;
    assign carrier_sense_out_o           = r.crs;
    assign receive_error_out_o           = r.rxer;
    assign receive_nibble_o              = r.nib;
    assign collision_indicator_o         = r.act[0];
    assign transmit_activity_indicator_o = r.act[1];
    assign receive_activity_indicator_o  = r.act[2];
    assign codec_bypass_o                = r.codec;
    assign aligner_bypass_o              = r.align;
    assign scrambler_bypass_o            = r.scr;
    assign carrier_integrity_enable_o    = r.carin;
    assign collision_carrier_out_o       = r.colcrs;
    assign far_end_fault_enable_o        = r.fef;
    assign fiber_mode_o                  = r.fiber;
    assign soft_reset_o                  = r.srst;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_status_link_bits: assert property (  // see RULE_01 RULE_02
        mgmt.regad == REG_STATUS |-> mgmt.rdata == {14'h0000, fast_link_up_i, slow_link_up_i})
        else $error("status link bits wrong");

    a_soft_reset_load: assert property (  // see RULE_03
        (mgmt.wr && mgmt.regad == REG_CTRL && mgmt.wdata[F_SRST])
        |=> (r.ctl == CTRL_RESET[14:0] && soft_reset_o) ##1 !soft_reset_o)
        else $error("soft reset wrong");

    a_tx_off_drive: assert property (  // see RULE_04
        !r.ctl[F_TXON] |=> !pair_out_pos_o && pair_out_neg_o)
        else $error("pair not idled");

    a_blink_merge: assert property (  // see RULE_05
        1'b1 |=> indicator_blink_o == $past(r.ctl[F_BLINK] | sy[S_BLINK]))
        else $error("blink enable wrong");

    a_carrier_select: assert property (  // see RULE_06
        (tx_active_i && !rx_active_i)
        |=> carrier_sense_out_o == !$past(r.ctl[F_CRS] | sy[S_CRS]))
        else $error("crs select wrong");

    a_link_err_code: assert property (  // see RULE_07
        (rx_err_i && r.ctl[F_LNKERR] && link_fault_i)
        |=> receive_error_out_o && receive_nibble_o == LINK_ERR_CODE)
        else $error("link code missing");

    a_packet_error_report_enable_code: assert property (  // see RULE_08
        (rx_err_i && !r.ctl[F_LNKERR] && r.ctl[F_PKTERR] && scr_unlocked_i)
        |=> receive_nibble_o == PACKET_ERROR_REPORT_ENABLE_CODE)
        else $error("pkt code missing");

    a_stretch_hold: assert property (  // see RULE_09
        ($fell(col_i) && r.ctl[F_STR]) ##1 (!col_i && r.ctl[F_STR]) [*3]
        |=> collision_indicator_o)
        else $error("no stretch");

    a_stretch_off: assert property (  // see RULE_09
        (!col_i && !r.ctl[F_STR]) |=> !collision_indicator_o)
        else $error("stretch while off");

    a_bypass_merge: assert property (  // see RULE_10 RULE_12
        1'b1 |=> codec_bypass_o == $past(r.ctl[F_CODEC] | sy[S_CODEC])
                 && scrambler_bypass_o == $past(r.ctl[F_SCR] | sy[S_SCR]))
        else $error("bypass merge wrong");

    a_jam_merge: assert property (  // see RULE_14
        (jam_i && r.ctl[F_JAM]) |=> collision_carrier_out_o)
        else $error("jam not merged");

    a_fiber_merge: assert property (  // see RULE_17
        (r.ctl[F_FIBER] || sy[S_FIBER]) |=> fiber_mode_o)
        else $error("fiber mode not set");

    a_ctrl_readback: assert property (  // see RULE_18
        (mgmt.wr && mgmt.regad == REG_CTRL && !mgmt.wdata[F_SRST])
        |=> r.ctl == $past(mgmt.wdata[14:0]))
        else $error("readback wrong");
endmodule
`default_nettype wire

/* File: verification/pfl_smc_model.sv */
// Purpose: station management controller sending frames on mdc/mdio
// Assumes: phy address 0, half period of mdc set by hp_i in mclk cycles
// Notes:   mdc stands low between frames; released data line floats to pull-up
`timescale 1ns/10ps
`default_nettype none
module pfl_smc_model
    import pfl_pkg::*;
(
    input  wire logic        mclk_i,  // system clock
    input  wire logic        mdio_i,  // resolved wire
    input  wire logic [3:0]  hp_i,    // mdc half period
    output logic             mdc_o,   // mgmt clock
    output logic             md_o,    // data driven
    output logic             md_oe_o, // drive enable
    output logic             rv_o,    // read done
    output logic [15:0]      rd_o     // read data
);
    initial
    begin
        {mdc_o, md_o, md_oe_o, rv_o, rd_o} = 20'h40000;
    end
    // one frame msb first; read bits taken at mdc rise
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
        logic [31:0] f;
        f = {2'b01, op, 5'h00, ra, 2'b10, wd};
        for (int i = 0; i < 32; i++)
        begin
            md_o = f[31-i];
            md_oe_o = !(op == OP_READ && i > 13); // let go for turnaround
            repeat (hp_i) @(posedge mclk_i);
            #1 mdc_o = 1'b1;
            if (i > 15)
                rd_o[31-i] = mdio_i;
            repeat (hp_i) @(posedge mclk_i);
            #1 mdc_o = 1'b0;
        end
        md_oe_o = 1'b0;
        rv_o = (op == OP_READ);
        repeat (5) @(posedge mclk_i);
        #1 rv_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/phy_fast_link_control_status_bench.sv */
// Purpose: self-checking bench for the fast link control block
// Assumes: stretch shortened to 20 cycles
// Notes:   reads queued, checked as each frame ends
`timescale 1ns/10ps
`default_nettype none
module phy_fast_link_control_status_bench;
    import pfl_pkg::*;
    logic        mclk = 1'b0;   // system clock
    logic        arst_n = 1'b0; // reset, low
    logic [3:0]  hp = 4'h4;     // mdc half period
    logic [5:0]  pin = '0;      // blink crs codec scr carin fiber
    logic [9:0]  s = '0;        // fast slow txp txn rxa txa err lf su col
    logic        jam = 1'b0;    // integrity jam
    logic [3:0]  nib = '0;      // receive data in
    logic [15:0] w;             // control word
    logic [14:0] e;             // expected port levels
    logic [31:0] r = 32'h5fd6;  // random state
    logic [15:0] expq[$];       // pending reads
    int          failures = 0, checks_done = 0, pulses = 0;
    wire         mdc, md, md_oe, rv, mo, mo_oe, sr;
    wire  [15:0] rd;
    wire  [14:0] q;
    wire  [3:0]  nq;
    wire         mdio = mo_oe ? mo : (md_oe ? md : 1'b1); // pull-up when idle
    always #25 mclk = ~mclk;
    pfl_smc_model smc (.mclk_i(mclk), .mdio_i(mdio), .hp_i(hp), .mdc_o(mdc), .md_o(md), .md_oe_o(md_oe),
        .rv_o(rv), .rd_o(rd));
    pfl_ctrl #(.STRETCH_CYC(20)) uut (.mclk_i(mclk), .arst_n_i(arst_n), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(mo),
        .mdio_oe_o(mo_oe), .fast_link_up_i(s[9]), .slow_link_up_i(s[8]), .tx_pos_i(s[7]), .tx_neg_i(s[6]),
        .pair_out_pos_o(q[0]), .pair_out_neg_o(q[1]), .indicator_blink_input_i(pin[5]), .indicator_blink_o(q[2]),
        .carrier_sense_receive_only_i(pin[4]), .rx_active_i(s[5]), .tx_active_i(s[4]), .carrier_sense_out_o(q[3]),
        .rx_err_i(s[3]), .rx_nibble_i(nib), .link_fault_i(s[2]), .scr_unlocked_i(s[1]), .receive_error_out_o(q[4]),
        .receive_nibble_o(nq), .col_i(s[0]), .collision_indicator_o(q[5]), .transmit_activity_indicator_o(q[13]),
        .receive_activity_indicator_o(q[14]), .codec_bypass_pin_i(pin[3]), .codec_bypass_o(q[6]),
        .aligner_bypass_o(q[7]), .scrambler_bypass_pin_i(pin[2]), .scrambler_bypass_o(q[8]),
        .carrier_integrity_enable_i(pin[1]), .carrier_integrity_enable_o(q[9]), .jam_i(jam),
        .collision_carrier_out_o(q[10]), .far_end_fault_enable_o(q[11]), .fiber_mode_input_i(pin[0]),
        .fiber_mode_o(q[12]), .soft_reset_o(sr));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        checks_done++;
        if (g !== x)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd_exp(input logic [4:0] a, input logic [15:0] x);
        expq.push_back(x);
        smc.frame(OP_READ, a, 16'h0);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // oldest note against each finished read
    always @(posedge rv) chk("read", expq.pop_front(), rd);
    always @(posedge mclk) pulses += (sr === 1'b1);
    // a hang is a mismatch; tests take about 8500 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        conclude();
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        #1 arst_n = 1'b1;
        s[7] = 1'b1;
        rd_exp(REG_CTRL, CTRL_RESET);
        chk("pair", 16'h1, 16'(q[1:0]));
        s[9] = 1'b1;
        rd_exp(REG_STATUS, 16'h0002);
        s[9:8] = 2'b01;
        rd_exp(REG_STATUS, 16'h0001);
        $display("test defaults done");
        // pins masked on even passes so register bits show alone
        for (int k = 0; k < 8; k++)
        begin
            r = lfsr(r);
            w = r[15:0] & 16'h7fff; // soft reset bit kept clear in loop
            r = lfsr(r);
            {pin, s[6:0], jam, nib} = r[17:0] & {{6{k[0]}}, 12'hfff};
            hp = k[0] ? 4'h4 : 4'h7;
            smc.frame(OP_WRITE, REG_CTRL, w);
            rd_exp(REG_CTRL, w);
            e = {s[5:4], w[0] | pin[0], w[1], s[0] | (jam & w[2]), w[3] | pin[1], w[4] | pin[2], w[5],
                 w[6] | pin[3], s[0], s[3], s[5] | (s[4] & ~(w[10] | pin[4])), w[11] | pin[5], ~w[12] | s[6], w[12] & s[7]};
            chk("ports", 16'(e), 16'(q));
            chk("nibble", 16'(!s[3] ? nib : (w[9] & s[2]) ? 4'h2 : (w[8] & s[1]) ? 4'h3 : nib), 16'(nq));
        end
        $display("test fields done");
        smc.frame(OP_WRITE, REG_CTRL, 16'h1080);
        s = s | 10'h031;
        @(posedge mclk);
        #1 s = s & 10'h3ce;
        repeat (12) @(posedge mclk);
        #1 chk("stretch", 16'h7, 16'({q[14:13], q[5]}));
        repeat (20) @(posedge mclk);
        #1 chk("stretch", 16'h0, 16'({q[14:13], q[5]}));
        $display("test stretch done");
        smc.frame(2'b11, REG_CTRL, 16'hffff);
        smc.frame(OP_WRITE, REG_STATUS, 16'hffff);
        rd_exp(REG_CTRL, 16'h1080);
        smc.frame(OP_WRITE, REG_CTRL, 16'hefff);
        chk("pulses", 16'h1, 16'(pulses));
        rd_exp(REG_CTRL, CTRL_RESET);
        rd_exp(5'h1e, 16'h0);
        $display("test reset done");
        conclude();
    end
endmodule
`default_nettype wire
